/* File: src/cmac_params.svh */
`ifndef CMAC_PARAMS_SVH
`define CMAC_PARAMS_SVH

// memory partition sizes in bytes
`define CMAC_ROM_APP_BYTES   393216
`define CMAC_ROM_TEST_BYTES  131072
`define CMAC_EE_TOTAL_BYTES  147456
`define CMAC_EE_MFR_BYTES    512
`define CMAC_EE_SUP_BYTES    768
`define CMAC_RAM_FW_BYTES    512
`define CMAC_RAM_GEN_BYTES   5120
`define CMAC_RAM_SHR_BYTES   2688

// vector table placement, all inside rom
`define CMAC_VEC_EXC_BASE    19'h00000
`define CMAC_VEC_IRQ_BASE    19'h00080
`define CMAC_VEC_SVC_BASE    19'h00100
`define CMAC_VEC_APP_RESET   19'h00200
`define CMAC_VEC_BOOT_ENTRY  19'h60000
`define CMAC_VEC_FW_BASE     19'h60100
`define CMAC_VEC_TEST_ENTRY  19'h60400
`define CMAC_VEC_STRIDE_LOG2 2
`define CMAC_EXC_IDX_VIOL    5'h00

// user rights word: bit positions and reset value
`define CMAC_UR_ROM_RD  0
`define CMAC_UR_EE_RD   1
`define CMAC_UR_EE_WR   2
`define CMAC_UR_RAM_GEN 3
`define CMAC_UR_RAM_SHR 4
`define CMAC_UR_SFR_RD  5
`define CMAC_UR_SFR_WR  6
`define CMAC_UR_RESET   7'h00

// test lock input sync reset level (locked is the safe value)
`define CMAC_LOCK_SYNC_RESET 1'b1

`endif

/* File: src/cmac_pkg.sv */
package cmac_pkg;

  typedef enum logic [2:0] {
    CMAC_M_BOOT,
    CMAC_M_TEST,
    CMAC_M_FW,
    CMAC_M_SYS,
    CMAC_M_USER
  } cmac_mode_t;

  typedef enum logic [1:0] {
    CMAC_SP_ROM,
    CMAC_SP_EE,
    CMAC_SP_RAM,
    CMAC_SP_SFR
  } cmac_space_t;

  typedef enum logic [3:0] {
    CMAC_R_ROM_APP,
    CMAC_R_ROM_TEST,
    CMAC_R_EE_MFR,
    CMAC_R_EE_SUP,
    CMAC_R_EE_APP,
    CMAC_R_RAM_FW,
    CMAC_R_RAM_GEN,
    CMAC_R_RAM_SHR,
    CMAC_R_SFR,
    CMAC_R_NONE
  } cmac_region_t;

  typedef enum logic [2:0] {
    CMAC_J_EXC,
    CMAC_J_IRQ,
    CMAC_J_FIRMWARE_ENTRY_VECTOR,
    CMAC_J_SYSTEM_CALL_VECTOR,
    CMAC_J_RET,
    CMAC_J_USER,
    CMAC_J_BOOT_DONE
  } cmac_jump_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    cmac_space_t space;
    logic [18:0] addr;
  } cmac_acc_t;

  typedef struct packed {
    logic            valid;
    cmac_jump_kind_t kind;
    logic [4:0]      index;
    logic [18:0]     target;
  } cmac_jump_t;

endpackage : cmac_pkg

/* File: src/cmac_region_decode.sv */
`timescale 1ns/1ns
`include "cmac_params.svh"

// maps a space and byte address onto its protection region
module cmac_region_decode
  import cmac_pkg::*;
#(
  parameter int EE_BYTES = `CMAC_EE_TOTAL_BYTES
)(
  input  cmac_space_t  space,
  input  wire [18:0]   addr,
  output cmac_region_t region
);

  localparam logic [18:0] ROM_SPLIT = 19'(`CMAC_ROM_APP_BYTES);
  localparam logic [19:0] ROM_END   = 20'(`CMAC_ROM_APP_BYTES + `CMAC_ROM_TEST_BYTES);
  localparam logic [18:0] EE_MFR_E  = 19'(`CMAC_EE_MFR_BYTES);
  localparam logic [18:0] EE_SUP_E  = 19'(`CMAC_EE_MFR_BYTES + `CMAC_EE_SUP_BYTES);
  localparam logic [18:0] EE_END    = 19'(EE_BYTES);
  localparam logic [18:0] RAM_FW_E  = 19'(`CMAC_RAM_FW_BYTES);
  localparam logic [18:0] RAM_GEN_E = 19'(`CMAC_RAM_FW_BYTES + `CMAC_RAM_GEN_BYTES);
  localparam logic [18:0] RAM_END   = 19'(`CMAC_RAM_FW_BYTES + `CMAC_RAM_GEN_BYTES + `CMAC_RAM_SHR_BYTES);

  // fixed partition; addresses past the end fall into no region
  always_comb
  begin
    region = CMAC_R_NONE;
    case (space)
      CMAC_SP_ROM:
      begin
        if (addr < ROM_SPLIT)               region = CMAC_R_ROM_APP;
        else if ({1'b0, addr} < ROM_END)    region = CMAC_R_ROM_TEST;
      end
      CMAC_SP_EE:
      begin
        if (addr < EE_MFR_E)                region = CMAC_R_EE_MFR;
        else if (addr < EE_SUP_E)           region = CMAC_R_EE_SUP;
        else if (addr < EE_END)             region = CMAC_R_EE_APP;
      end
      CMAC_SP_RAM:
      begin
        if (addr < RAM_FW_E)                region = CMAC_R_RAM_FW;
        else if (addr < RAM_GEN_E)          region = CMAC_R_RAM_GEN;
        else if (addr < RAM_END)            region = CMAC_R_RAM_SHR;
      end
      CMAC_SP_SFR: region = CMAC_R_SFR;
      default:     region = CMAC_R_NONE;
    endcase
  end

endmodule : cmac_region_decode

/* File: src/cmac_top.sv */
`timescale 1ns/1ns
`include "cmac_params.svh"

// Functional notes
// - five modes; boot, test and firmware together form the super-system group.
// - system and user software reach super modes only through firmware vectors.
// - while test is not locked, each reset ends in test mode in test rom.
// - once test is locked, each reset ends in system mode; test unreachable.
// - system mode reaches every application resource and every sfr.
// - user mode limited by rights word that only system mode may write.
// - each exception and interrupt jumps to its own fixed rom vector.
// - eight firmware vectors; jumping to one enters firmware mode.
// - thirty-two system call vectors; jumping to one enters system mode.
// - test mode reads and writes every memory region freely.
// - boot and firmware reach test rom, maker and support eeprom, firmware ram.
// - system and user reach application rom, eeprom, ram and sfrs only.
// - rom splits into 384 kbyte application and 128 kbyte test parts.
// - eeprom keeps 512 maker bytes and 768 support software bytes.
// - ram keeps 512 firmware bytes, the rest for application.
// - application ram is general plus shared; coprocessor reaches shared only.
// - coprocessor access to shared ram skips all mode and rights checks.
module cmac_top
  import cmac_pkg::*;
#(
  parameter int EE_BYTES = `CMAC_EE_TOTAL_BYTES
)(
  input  wire         clk,
  input  wire         rst,
  input  wire         test_lock_pin,
  input  cmac_acc_t   cpu_acc,
  output logic        acc_grant,
  output logic        acc_deny,
  input  cmac_jump_t  cpu_jump,
  output logic        jump_ack,
  output logic        pc_load,
  output logic [18:0] pc_target,
  input  wire         rights_wr,
  input  wire  [6:0]  rights_data,
  output logic        rights_ack,
  input  wire         cop_valid,
  input  wire  [18:0] cop_addr,
  output logic        cop_grant,
  output logic        cop_deny,
  output cmac_mode_t  mode,
  output logic        super_mode,
  output logic        test_locked
);

  cmac_mode_t   mode_ff;
  cmac_mode_t   nxt_mode;
  cmac_mode_t   caller_ff;
  logic [18:0]  pc_ff;
  logic [18:0]  nxt_pc;
  logic         pc_load_ff;
  logic         nxt_pc_load;
  logic [6:0]   rights_ff;
  logic         lock_s1_ff;
  logic         lock_s2_ff;
  logic         lock_s3_ff;
  logic         locked_ff;
  cmac_region_t cpu_region;
  cmac_region_t cop_region;
  logic         jump_ok;

  // vector address from table base and slot number
  function automatic logic [18:0] vec_addr(input logic [18:0] base, input logic [4:0] idx);
    vec_addr = base + {12'h000, idx, 2'b00};
  endfunction : vec_addr

  // permission of one cpu access for a mode and rights word
  function automatic logic cpu_allowed(input cmac_mode_t m, input cmac_region_t r,
                                       input logic wr, input logic [6:0] ur);
    logic ok;
    ok = 1'b0;
    case (m)
      CMAC_M_TEST: ok = (r != CMAC_R_NONE);
      CMAC_M_BOOT,
      CMAC_M_FW:
        ok = (r == CMAC_R_ROM_TEST && !wr) || r == CMAC_R_EE_MFR || r == CMAC_R_EE_SUP
             || r == CMAC_R_RAM_FW || r == CMAC_R_SFR;
      CMAC_M_SYS:
        ok = (r == CMAC_R_ROM_APP && !wr) || r == CMAC_R_EE_APP || r == CMAC_R_RAM_GEN
             || r == CMAC_R_RAM_SHR || r == CMAC_R_SFR;
      CMAC_M_USER:
        case (r)
          CMAC_R_ROM_APP: ok = !wr && ur[`CMAC_UR_ROM_RD];
          CMAC_R_EE_APP:  ok = wr ? ur[`CMAC_UR_EE_WR] : ur[`CMAC_UR_EE_RD];
          CMAC_R_RAM_GEN: ok = ur[`CMAC_UR_RAM_GEN];
          CMAC_R_RAM_SHR: ok = ur[`CMAC_UR_RAM_SHR];
          CMAC_R_SFR:     ok = wr ? ur[`CMAC_UR_SFR_WR] : ur[`CMAC_UR_SFR_RD];
          default:        ok = 1'b0;
        endcase
      default: ok = 1'b0;
    endcase
    cpu_allowed = ok;
  endfunction : cpu_allowed

  cmac_region_decode #(.EE_BYTES(EE_BYTES)) u_cpu_dec (
    .space  (cpu_acc.space),
    .addr   (cpu_acc.addr),
    .region (cpu_region)
  );

  cmac_region_decode #(.EE_BYTES(EE_BYTES)) u_cop_dec (
    .space  (CMAC_SP_RAM),
    .addr   (cop_addr),
    .region (cop_region)
  );

  // lock fuse level crosses in from outside; three stages, change taken when 2 and 3 agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_s1_ff <= `CMAC_LOCK_SYNC_RESET;
      lock_s2_ff <= `CMAC_LOCK_SYNC_RESET;
      lock_s3_ff <= `CMAC_LOCK_SYNC_RESET;
    end
    else
    begin
      lock_s1_ff <= test_lock_pin;
      lock_s2_ff <= lock_s1_ff;
      lock_s3_ff <= lock_s2_ff;
    end
  end

  // filtered lock; follows the filter in boot, once set outside boot it holds until reset, so a glitch cannot reopen test
  always_ff @(posedge clk)
  begin
    if (rst)
      locked_ff <= `CMAC_LOCK_SYNC_RESET;
    else if (lock_s2_ff == lock_s3_ff && (lock_s3_ff || mode_ff == CMAC_M_BOOT))
      locked_ff <= lock_s3_ff | (locked_ff & (mode_ff != CMAC_M_BOOT));
  end

  // cpu access check; blocked accesses never reach the memories
  always_comb
  begin
    acc_grant = cpu_acc.valid && cpu_allowed(mode_ff, cpu_region, cpu_acc.write, rights_ff);
    acc_deny  = cpu_acc.valid && !acc_grant;
  end

  // coprocessor sees only shared ram, independent of cpu mode and rights
  always_comb
  begin
    cop_grant = cop_valid && (cop_region == CMAC_R_RAM_SHR);
    cop_deny  = cop_valid && !cop_grant;
  end

  // which jump requests are legal in the present mode; a violation in the same cycle wins
  always_comb
  begin
    jump_ok = 1'b0;
    case (cpu_jump.kind)
      CMAC_J_EXC,
      CMAC_J_IRQ:       jump_ok = 1'b1;
      CMAC_J_FIRMWARE_ENTRY_VECTOR:      jump_ok = (cpu_jump.index[4:3] == 2'b00);
      CMAC_J_SYSTEM_CALL_VECTOR:      jump_ok = (mode_ff != CMAC_M_BOOT);
      CMAC_J_RET:       jump_ok = (mode_ff == CMAC_M_FW);
      CMAC_J_USER:      jump_ok = (mode_ff == CMAC_M_SYS);
      CMAC_J_BOOT_DONE: jump_ok = (mode_ff == CMAC_M_BOOT);
      default:          jump_ok = 1'b0;
    endcase
    jump_ack = cpu_jump.valid && jump_ok && !acc_deny;
  end

  // next mode and program counter
  always_comb
  begin
    nxt_mode    = mode_ff;
    nxt_pc      = pc_ff;
    nxt_pc_load = 1'b0;
    if (acc_deny)
    begin
      nxt_pc      = vec_addr(`CMAC_VEC_EXC_BASE, `CMAC_EXC_IDX_VIOL);
      nxt_pc_load = 1'b1;
      if (mode_ff != CMAC_M_TEST)
        nxt_mode = CMAC_M_SYS;
    end
    else if (jump_ack)
    begin
      nxt_pc_load = 1'b1;
      case (cpu_jump.kind)
        CMAC_J_EXC:
        begin
          nxt_pc = vec_addr(`CMAC_VEC_EXC_BASE, cpu_jump.index);
          if (mode_ff != CMAC_M_TEST)
            nxt_mode = CMAC_M_SYS;
        end
        CMAC_J_IRQ:
        begin
          nxt_pc = vec_addr(`CMAC_VEC_IRQ_BASE, cpu_jump.index);
          if (mode_ff != CMAC_M_TEST)
            nxt_mode = CMAC_M_SYS;
        end
        CMAC_J_FIRMWARE_ENTRY_VECTOR:
        begin
          nxt_pc   = vec_addr(`CMAC_VEC_FW_BASE, cpu_jump.index);
          nxt_mode = CMAC_M_FW;
        end
        CMAC_J_SYSTEM_CALL_VECTOR:
        begin
          nxt_pc   = vec_addr(`CMAC_VEC_SVC_BASE, cpu_jump.index);
          nxt_mode = CMAC_M_SYS;
        end
        CMAC_J_RET:
        begin
          nxt_pc   = cpu_jump.target;
          nxt_mode = caller_ff;
        end
        CMAC_J_USER:
        begin
          nxt_pc   = cpu_jump.target;
          nxt_mode = CMAC_M_USER;
        end
        CMAC_J_BOOT_DONE:
        begin
          if (locked_ff)
          begin
            nxt_pc   = `CMAC_VEC_APP_RESET;
            nxt_mode = CMAC_M_SYS;
          end
          else
          begin
            nxt_pc   = `CMAC_VEC_TEST_ENTRY;
            nxt_mode = CMAC_M_TEST;
          end
        end
        default: nxt_pc_load = 1'b0;
      endcase
    end
  end

  // mode state; reset always passes through boot first
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_ff <= CMAC_M_BOOT;
    else
      mode_ff <= nxt_mode;
  end

  // caller mode saved on firmware entry from outside firmware; a user caller returns to user, any other caller to system
  always_ff @(posedge clk)
  begin
    if (rst)
      caller_ff <= CMAC_M_SYS;
    else if (jump_ack && cpu_jump.kind == CMAC_J_FIRMWARE_ENTRY_VECTOR && mode_ff != CMAC_M_FW)
      caller_ff <= (mode_ff == CMAC_M_USER) ? CMAC_M_USER : CMAC_M_SYS;
  end

  // jump target and its one-cycle load strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_ff      <= `CMAC_VEC_BOOT_ENTRY;
      pc_load_ff <= 1'b0;
    end
    else
    begin
      pc_ff      <= nxt_pc;
      pc_load_ff <= nxt_pc_load;
    end
  end

  // user rights word, writable only from system mode
  always_ff @(posedge clk)
  begin
    if (rst)
      rights_ff <= `CMAC_UR_RESET;
    else if (rights_wr && mode_ff == CMAC_M_SYS)
      rights_ff <= rights_data;
  end

  assign rights_ack  = rights_wr && (mode_ff == CMAC_M_SYS);
  assign pc_load     = pc_load_ff;
  assign pc_target   = pc_ff;
  assign mode        = mode_ff;
  assign super_mode  = (mode_ff == CMAC_M_BOOT) || (mode_ff == CMAC_M_TEST) || (mode_ff == CMAC_M_FW);
  assign test_locked = locked_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_firmware_entry_vector_taken;
    jump_ack && cpu_jump.kind == CMAC_J_FIRMWARE_ENTRY_VECTOR;
  endsequence

  sequence s_boot_exit;
    jump_ack && cpu_jump.kind == CMAC_J_BOOT_DONE;
  endsequence

  chk_mode_legal: assert property (
    mode_ff inside {CMAC_M_BOOT, CMAC_M_TEST, CMAC_M_FW, CMAC_M_SYS, CMAC_M_USER}
    && (super_mode == (mode_ff inside {CMAC_M_BOOT, CMAC_M_TEST, CMAC_M_FW})))
    else $error("mode outside the five legal modes");

  chk_super_entry_only: assert property (
    $past(mode_ff) inside {CMAC_M_SYS, CMAC_M_USER} && super_mode
    |-> $past(jump_ack) && $past(cpu_jump.kind) == CMAC_J_FIRMWARE_ENTRY_VECTOR)
    else $error("super mode entered without firmware vector");

  chk_reset_to_test: assert property (
    s_boot_exit ##0 !locked_ff |=> mode_ff == CMAC_M_TEST && pc_load && pc_target == `CMAC_VEC_TEST_ENTRY)
    else $error("unlocked boot did not finish in test mode");

  chk_reset_to_sys: assert property (
    s_boot_exit ##0 locked_ff |=> mode_ff == CMAC_M_SYS && pc_target == `CMAC_VEC_APP_RESET)
    else $error("locked boot did not finish in system mode");

  chk_test_closed: assert property (
    locked_ff && mode_ff != CMAC_M_TEST |=> mode_ff != CMAC_M_TEST)
    else $error("test mode reached after lock");

  chk_firmware_entry_vector_entry: assert property (
    s_firmware_entry_vector_taken |=> mode_ff == CMAC_M_FW && pc_load
      && pc_target == `CMAC_VEC_FW_BASE + {12'h000, $past(cpu_jump.index), 2'b00})
    else $error("firmware vector did not enter firmware mode");

  chk_system_call_vector_entry: assert property (
    jump_ack && cpu_jump.kind == CMAC_J_SYSTEM_CALL_VECTOR |=> mode_ff == CMAC_M_SYS
      && pc_target == `CMAC_VEC_SVC_BASE + {12'h000, $past(cpu_jump.index), 2'b00})
    else $error("system call vector did not enter system mode");

  chk_test_free: assert property (
    mode_ff == CMAC_M_TEST && cpu_acc.valid && cpu_region != CMAC_R_NONE |-> acc_grant)
    else $error("test mode access refused");

  chk_fw_fence: assert property (
    mode_ff inside {CMAC_M_BOOT, CMAC_M_FW} && cpu_acc.valid
      && cpu_region inside {CMAC_R_ROM_APP, CMAC_R_EE_APP, CMAC_R_RAM_GEN, CMAC_R_RAM_SHR} |-> acc_deny)
    else $error("firmware mode reached application memory");

  chk_app_fence: assert property (
    mode_ff inside {CMAC_M_SYS, CMAC_M_USER} && cpu_acc.valid
      && cpu_region inside {CMAC_R_ROM_TEST, CMAC_R_EE_MFR, CMAC_R_EE_SUP, CMAC_R_RAM_FW} |-> acc_deny)
    else $error("application mode reached reserved memory");

  chk_cop_shared: assert property (
    cop_valid |-> cop_grant == (cop_addr >= 19'(`CMAC_RAM_FW_BYTES + `CMAC_RAM_GEN_BYTES)
      && cop_addr < 19'(`CMAC_RAM_FW_BYTES + `CMAC_RAM_GEN_BYTES + `CMAC_RAM_SHR_BYTES)))
    else $error("coprocessor shared ram decision wrong");

  chk_viol_vector: assert property (
    acc_deny |-> !acc_grant ##1 pc_load && pc_target == `CMAC_VEC_EXC_BASE
      ##1 !pc_load || $past(acc_deny) || $past(jump_ack))
    else $error("violation did not raise its exception");

endmodule : cmac_top

/* File: sim/cmac_cpu_model.sv */
`timescale 1ns/1ns

// cpu core stand-in: one access or one jump per call, launched on a falling edge
module cmac_cpu_model
  import cmac_pkg::*;
(
  input  wire        clk,
  input  wire        acc_grant,
  input  wire        acc_deny,
  input  wire        jump_ack,
  output cmac_acc_t  cpu_acc,
  output cmac_jump_t cpu_jump
);
  initial
  begin
    cpu_acc  = '0;
    cpu_jump = '0;
  end

  // request stands over the taking edge; answers are combinational, so read mid-cycle
  task automatic acc(input logic w, input cmac_space_t s, input logic [18:0] a, output logic g, output logic d);
    @(negedge clk);
    cpu_acc <= '{1'h1, w, s, a};
    #5;
    g = acc_grant;
    d = acc_deny;
    @(negedge clk);
    // released write and address fields flip so nothing can lean on a stale address
    cpu_acc <= '{1'h0, ~w, s, ~a};
  endtask : acc

  // vector or mode jump, same holding pattern as an access
  task automatic jmp(input cmac_jump_kind_t k, input logic [4:0] i, input logic [18:0] t, output logic ack);
    @(negedge clk);
    cpu_jump <= '{1'h1, k, i, t};
    #5;
    ack = jump_ack;
    @(negedge clk);
    cpu_jump <= '{1'h0, k, ~i, ~t};
  endtask : jmp
endmodule : cmac_cpu_model

/* File: sim/cmac_top_tb.sv */
`timescale 1ns/1ns

// walks reset paths, vector switching and the per-mode memory partition
module cmac_top_tb
  import cmac_pkg::*;
;
  typedef struct packed {
    cmac_mode_t  md;
    logic        w;
    cmac_space_t sp;
    logic [18:0] a;
    logic        g;
  } cmac_row_t;

  logic        clk, rst, test_lock_pin, rights_wr, cop_valid;
  logic [6:0]  rights_data;
  logic [18:0] cop_addr, pc_target;
  cmac_acc_t   cpu_acc;
  cmac_jump_t  cpu_jump;
  cmac_mode_t  mode;
  logic        acc_grant, acc_deny, jump_ack, pc_load, rights_ack, cop_grant, cop_deny, super_mode, test_locked;
  int          bad_count, num_checks;
  cmac_row_t   rows[$];

  always #20 clk = ~clk;

  cmac_top u_dut (.clk(clk), .rst(rst), .test_lock_pin(test_lock_pin), .cpu_acc(cpu_acc),
    .acc_grant(acc_grant), .acc_deny(acc_deny), .cpu_jump(cpu_jump), .jump_ack(jump_ack),
    .pc_load(pc_load), .pc_target(pc_target), .rights_wr(rights_wr), .rights_data(rights_data),
    .rights_ack(rights_ack), .cop_valid(cop_valid), .cop_addr(cop_addr), .cop_grant(cop_grant),
    .cop_deny(cop_deny), .mode(mode), .super_mode(super_mode), .test_locked(test_locked));

  cmac_cpu_model u_cpu (.clk(clk), .acc_grant(acc_grant), .acc_deny(acc_deny), .jump_ack(jump_ack),
    .cpu_acc(cpu_acc), .cpu_jump(cpu_jump));

  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_addr(input logic [18:0] g, input logic [18:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_addr

  task automatic chk_mode(input cmac_mode_t g, input cmac_mode_t e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_mode

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // a denied access must also bounce the pc to the violation vector
  task automatic ac(input logic w, input cmac_space_t s, input logic [18:0] a, input logic eg);
    logic       g, d;
    cmac_mode_t m0;
    m0 = mode;
    u_cpu.acc(w, s, a, g, d);
    chk_bit(g, eg);
    chk_bit(d, ~eg);
    chk_bit(pc_load, ~eg);
    if (!eg)
    begin
      chk_addr(pc_target, 19'h00000);
      chk_mode(mode, (m0 == CMAC_M_TEST) ? CMAC_M_TEST : CMAC_M_SYS);
    end
  endtask : ac

  // refused jumps must leave mode alone and load nothing
  task automatic jx(input cmac_jump_kind_t k, input logic [4:0] i, input logic [18:0] t, input logic ea,
                    input cmac_mode_t em, input logic [18:0] ep);
    logic ack;
    u_cpu.jmp(k, i, t, ack);
    chk_bit(ack, ea);
    chk_mode(mode, em);
    chk_bit(pc_load, ea);
    if (ea)
      chk_addr(pc_target, ep);
  endtask : jx

  // only jumps lead into firmware and user modes, so context setup goes through them too
  task automatic enter(input cmac_mode_t m);
    if (mode !== CMAC_M_SYS)
      jx(CMAC_J_SYSTEM_CALL_VECTOR, 5'h00, 19'h00000, 1'h1, CMAC_M_SYS, 19'h00100);
    if (m == CMAC_M_FW)
      jx(CMAC_J_FIRMWARE_ENTRY_VECTOR, 5'h00, 19'h00000, 1'h1, CMAC_M_FW, 19'h60100);
    if (m == CMAC_M_USER)
      jx(CMAC_J_USER, 5'h00, 19'h00400, 1'h1, CMAC_M_USER, 19'h00400);
  endtask : enter

  task automatic rwr(input logic [6:0] v, input logic ea);
    @(negedge clk);
    rights_wr   <= 1'h1;
    rights_data <= v;
    #5;
    chk_bit(rights_ack, ea);
    @(negedge clk);
    rights_wr   <= 1'h0;
    rights_data <= ~v;
  endtask : rwr

  task automatic cop(input logic [18:0] a, input logic eg);
    @(negedge clk);
    cop_valid <= 1'h1;
    cop_addr  <= a;
    #5;
    chk_bit(cop_grant, eg);
    chk_bit(cop_deny, ~eg);
    @(negedge clk);
    cop_valid <= 1'h0;
    cop_addr  <= ~a;
  endtask : cop

  // reset held eight cycles, then room for the three-flop fuse filter
  task automatic do_reset;
    rst = 1'h1;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    chk_mode(mode, CMAC_M_BOOT);
    chk_bit(super_mode, 1'h1);
    chk_addr(pc_target, 19'h60000);
    repeat (5) @(negedge clk);
  endtask : do_reset

  function automatic void add(cmac_mode_t m, logic w, cmac_space_t s, logic [18:0] a, logic g);
    rows.push_back('{m, w, s, a, g});
  endfunction : add

  // hang guard; a run this size needs under two hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    clk = 1'h0;
    test_lock_pin = 1'h0;
    {rights_wr, rights_data, cop_valid, cop_addr} = '0;
    bad_count = 0;
    num_checks = 0;
    add(CMAC_M_SYS, 1'h0, CMAC_SP_ROM, 19'h5FFFF, 1'h1);
    add(CMAC_M_SYS, 1'h0, CMAC_SP_ROM, 19'h60000, 1'h0);
    add(CMAC_M_SYS, 1'h1, CMAC_SP_ROM, 19'h00000, 1'h0);
    add(CMAC_M_SYS, 1'h0, CMAC_SP_EE, 19'h001FF, 1'h0);
    add(CMAC_M_SYS, 1'h0, CMAC_SP_EE, 19'h004FF, 1'h0);
    add(CMAC_M_SYS, 1'h1, CMAC_SP_EE, 19'h00500, 1'h1);
    add(CMAC_M_SYS, 1'h0, CMAC_SP_RAM, 19'h001FF, 1'h0);
    add(CMAC_M_SYS, 1'h1, CMAC_SP_RAM, 19'h00200, 1'h1);
    add(CMAC_M_SYS, 1'h1, CMAC_SP_RAM, 19'h0207F, 1'h1);
    add(CMAC_M_SYS, 1'h0, CMAC_SP_RAM, 19'h02080, 1'h0);
    add(CMAC_M_SYS, 1'h1, CMAC_SP_SFR, 19'h00010, 1'h1);
    add(CMAC_M_FW, 1'h0, CMAC_SP_ROM, 19'h60000, 1'h1);
    add(CMAC_M_FW, 1'h0, CMAC_SP_ROM, 19'h5FFFF, 1'h0);
    add(CMAC_M_FW, 1'h1, CMAC_SP_EE, 19'h001FF, 1'h1);
    add(CMAC_M_FW, 1'h0, CMAC_SP_EE, 19'h004FF, 1'h1);
    add(CMAC_M_FW, 1'h0, CMAC_SP_EE, 19'h00500, 1'h0);
    add(CMAC_M_FW, 1'h1, CMAC_SP_RAM, 19'h001FF, 1'h1);
    add(CMAC_M_FW, 1'h0, CMAC_SP_RAM, 19'h00200, 1'h0);
    add(CMAC_M_USER, 1'h0, CMAC_SP_ROM, 19'h00000, 1'h0);
    add(CMAC_M_USER, 1'h1, CMAC_SP_RAM, 19'h00200, 1'h0);
    do_reset();
    jx(CMAC_J_BOOT_DONE, 5'h00, 19'h00000, 1'h1, CMAC_M_TEST, 19'h60400);
    chk_bit(test_locked, 1'h0);
    chk_bit(super_mode, 1'h1);
    ac(1'h1, CMAC_SP_ROM, 19'h00000, 1'h1);
    ac(1'h1, CMAC_SP_EE, 19'h00500, 1'h1);
    ac(1'h0, CMAC_SP_RAM, 19'h01000, 1'h1);
    ac(1'h0, CMAC_SP_RAM, 19'h02080, 1'h0);
    $display("test unlocked start done");
    test_lock_pin = 1'h1;
    do_reset();
    ac(1'h0, CMAC_SP_EE, 19'h004FF, 1'h1);
    jx(CMAC_J_SYSTEM_CALL_VECTOR, 5'h00, 19'h00000, 1'h0, CMAC_M_BOOT, 19'h00000);
    jx(CMAC_J_BOOT_DONE, 5'h00, 19'h00000, 1'h1, CMAC_M_SYS, 19'h00200);
    chk_bit(test_locked, 1'h1);
    chk_bit(super_mode, 1'h0);
    test_lock_pin = 1'h0;
    repeat (5) @(negedge clk);
    jx(CMAC_J_BOOT_DONE, 5'h00, 19'h00000, 1'h0, CMAC_M_SYS, 19'h00000);
    $display("locked start done");
    foreach (rows[i])
    begin
      if (mode !== rows[i].md)
        enter(rows[i].md);
      ac(rows[i].w, rows[i].sp, rows[i].a, rows[i].g);
    end
    $display("partition table done");
    enter(CMAC_M_SYS);
    jx(CMAC_J_FIRMWARE_ENTRY_VECTOR, 5'h07, 19'h00000, 1'h1, CMAC_M_FW, 19'h6011C);
    jx(CMAC_J_FIRMWARE_ENTRY_VECTOR, 5'h08, 19'h00000, 1'h0, CMAC_M_FW, 19'h00000);
    jx(CMAC_J_RET, 5'h00, 19'h01234, 1'h1, CMAC_M_SYS, 19'h01234);
    jx(CMAC_J_USER, 5'h00, 19'h00400, 1'h1, CMAC_M_USER, 19'h00400);
    jx(CMAC_J_RET, 5'h00, 19'h00000, 1'h0, CMAC_M_USER, 19'h00000);
    jx(CMAC_J_BOOT_DONE, 5'h00, 19'h00000, 1'h0, CMAC_M_USER, 19'h00000);
    rwr(7'h01, 1'h0);
    jx(CMAC_J_FIRMWARE_ENTRY_VECTOR, 5'h02, 19'h00000, 1'h1, CMAC_M_FW, 19'h60108);
    jx(CMAC_J_RET, 5'h00, 19'h00500, 1'h1, CMAC_M_USER, 19'h00500);
    ac(1'h0, CMAC_SP_ROM, 19'h00000, 1'h0);
    jx(CMAC_J_SYSTEM_CALL_VECTOR, 5'h1F, 19'h00000, 1'h1, CMAC_M_SYS, 19'h0017C);
    rwr(7'h01, 1'h1);
    enter(CMAC_M_USER);
    ac(1'h0, CMAC_SP_ROM, 19'h00000, 1'h1);
    ac(1'h0, CMAC_SP_EE, 19'h00500, 1'h0);
    $display("vectors and rights done");
    jx(CMAC_J_IRQ, 5'h02, 19'h00000, 1'h1, CMAC_M_SYS, 19'h00088);
    jx(CMAC_J_EXC, 5'h01, 19'h00000, 1'h1, CMAC_M_SYS, 19'h00004);
    enter(CMAC_M_FW);
    jx(CMAC_J_IRQ, 5'h00, 19'h00000, 1'h1, CMAC_M_SYS, 19'h00080);
    $display("exceptions done");
    rwr(7'h00, 1'h1);
    enter(CMAC_M_USER);
    cop(19'h015FF, 1'h0);
    cop(19'h01600, 1'h1);
    cop(19'h0207F, 1'h1);
    cop(19'h02080, 1'h0);
    $display("coprocessor done");
    give_verdict();
  end
endmodule : cmac_top_tb
